//--- sps_defines.svh
// constants for the serial print gate: ascii codes, status codes, timing
// assumes inclusion by sps_gate.sv only
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_ESC      8'h1b
`define SPS_GATE_DEV 8'h59
`define SPS_GATE_PRN 8'h5a
`define SPS_COLON    8'h3a
`define SPS_CR       8'h0d
`define SPS_LF       8'h0a
`define SPS_SPACE    8'h20
`define SPS_LTR_S    8'h53
`define SPS_ST_S00   16'h3030
`define SPS_ST_S01   16'h3031
`define SPS_ST_S08   16'h3038
`define SPS_ST_S09   16'h3039
`define SPS_ST_S10   16'h3130
`define SPS_CMD_TC   16'h5443
`define SPS_CMD_PR   16'h5052
`define SPS_CMD_RPT  16'h543f
`define SPS_CLK_NS   8
`define SPS_GAP_MS   2000
`define SPS_FIFO_DEP 8
`endif

//--- sps_pkg.sv
// types shared by the serial print gate and its transmit fifo
// assumes nothing of its surroundings
package sps_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_MSG, ST_RPT, ST_CHK, ST_PCHK, ST_PERR, ST_PRINT}
        sps_state_e;
    typedef enum logic [1:0] {CMD_NONE, CMD_TC, CMD_PR, CMD_RPT} sps_cmd_e;
    typedef enum logic {GATE_DEV, GATE_PRN} sps_gate_e;
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } sps_byte_s;
endpackage

//--- sps_gate.sv
// serial print gate: command framing, gate switching, docket and status sequencing
// assumes byte-wide serial ports synchronous to sys_clk, one byte per valid cycle
//
// Behaviour
// RULE1: esc esc Y connects hand-held to device
// RULE2: esc esc Z passes hand-held to printer
// RULE3: end of delivery: gate home, finish, send S08
// RULE4: print own docket part only with paper; code checks paper only when slip42 is set
// RULE5: original printed: gate home, send S01
// RULE6: transaction complete answers S00, permits delivery
// RULE7: hand-held sends transaction complete early
// RULE8: slip printer: check paper, show error, poll
// RULE9: paper resumes print; stop sends S10
// RULE10: stop key or print request restarts printout
// RULE11: print request: duplicate if original done
// RULE12: hand-held silent after S08 or S09
// RULE13: test key never queries paper status
// RULE14: lines positioned for width, no other formatting
// RULE15: command framed by colon and carriage return
// RULE16: colon restarts buffer; unframed input ignored
// RULE17: gap over two seconds clears buffer
// RULE18: responses end with CR LF
// RULE19: half duplex, no echo
// RULE20: answer starts well under 160 ms
// RULE21: report checksum is negated byte sum
// RULE22: hand-held sums report to zero
// RULE23: printer gate forwards bytes, still watches escapes; code drops bytes while in ST_PRINT
`timescale 1ns/100ps
`include "sps_defines.svh"

// ----------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------
module sps_fifo import sps_pkg::*; #(
    parameter int W = 9,
    parameter int D = `SPS_FIFO_DEP
) (
    input  wire logic         sys_clk,  // system clock
    input  wire logic         arst_n,   // async reset
    input  wire logic [W-1:0] inData,   // write word
    input  wire logic         inValid,  // write request
    output logic              inReady,  // not full
    output logic [W-1:0]      outData,  // head word
    output logic              outValid, // not empty
    input  wire logic         outReady  // head taken
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
    logic         push, pop;

    assign inReady  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign outValid = (wr_q != rd_q);
    assign outData  = mem[rd_q[AW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        wr_d = wr_q + {{AW{1'b0}}, push};
        rd_d = rd_q + {{AW{1'b0}}, pop};
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= inData;
        end
    end
endmodule // sps_fifo

// ----------------------------------------------------------------
// gate and command sequencer
// ----------------------------------------------------------------
module sps_gate import sps_pkg::*; #(
    parameter int unsigned GAP_CYC = `SPS_GAP_MS * 1000000 / `SPS_CLK_NS
) (
    input  wire logic       sys_clk,        // 125 MHz clock
    input  wire logic       arst_n,         // async reset
    input  wire logic [7:0] hhRxData,       // byte from hand-held
    input  wire logic       hhRxValid,      // byte strobe
    output sps_byte_s       hhTx,           // byte to hand-held, last on LF
    output logic            hhTxValid,      // byte waiting
    input  wire logic       hhTxReady,      // hand-held line takes byte
    output logic [7:0]      prnTxData,      // byte to printer
    output logic            prnTxValid,     // byte waiting
    input  wire logic       prnTxReady,     // printer line takes byte
    input  wire logic       endOfDelivery,  // delivery ended pulse
    input  wire logic       stopKey,        // stop key pulse
    input  wire logic       paperPresent,   // printer paper status
    input  wire logic       slip42,         // 42-column slip printer fitted
    input  wire logic [7:0] devId,          // ascii id character
    input  sps_byte_s       srcData,        // docket or report text
    input  wire logic       srcValid,       // text byte waiting
    output logic            srcReady,       // text byte taken
    output logic            srcReq,         // text wanted
    output logic            srcDocket,      // 1 docket, 0 report
    output logic            printDup,       // docket is a duplicate
    output logic            gateToPrinter,  // hand-held passed to printer
    output logic            devToPrinter,   // device printing its docket
    output logic            paperError,     // paper error shown
    output logic            deliveryPermit  // new delivery allowed
);
    localparam logic [27:0] GAP_LAST = 28'(GAP_CYC - 1);

    function automatic logic [7:0] upcase(input logic [7:0] c);
        return (c >= 8'h61 && c <= 8'h7a) ? (c & 8'hdf) : c;
    endfunction

    function automatic sps_cmd_e decode(input logic [15:0] c);
        case (c)
            `SPS_CMD_TC:  return CMD_TC;
            `SPS_CMD_PR:  return CMD_PR;
            `SPS_CMD_RPT: return CMD_RPT;
            default:      return CMD_NONE;
        endcase
    endfunction

    function automatic logic [7:0] msgByte(input logic [2:0] i, input logic [15:0] code,
                                           input logic [7:0] id);
        case (i)
            3'h0:    return id;
            3'h1:    return `SPS_SPACE;
            3'h2:    return `SPS_LTR_S;
            3'h3:    return code[15:8];
            3'h4:    return code[7:0];
            3'h5:    return `SPS_CR;
            default: return `SPS_LF;
        endcase
    endfunction

    sps_state_e  st_q, st_d, ret_q, ret_d;
    sps_cmd_e    cmd_q, cmd_d;
    sps_gate_e   gate_q, gate_d;
    logic [15:0] code_q, code_d;
    logic [2:0]  idx_q, idx_d;
    logic [7:0]  sum_q, sum_d, prn_q, prn_d, c0_q, c0_d, c1_q, c1_d;
    logic [27:0] gap_q, gap_d;
    logic [1:0]  cnt_q, cnt_d, esc_q, esc_d;
    logic        orig_q, orig_d, txn_q, txn_d, eod_q, eod_d, dup_q, dup_d;
    logic        unpr_q, unpr_d, prnV_q, prnV_d, frm_q, frm_d;
    sps_byte_s   fIn;
    logic        fInV, fInReady;

    // ----------------------------------------------------------------
    // outgoing hand-held bytes
    // ----------------------------------------------------------------
    sps_fifo #(.W($bits(sps_byte_s)), .D(`SPS_FIFO_DEP)) u_txFifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .inData   (fIn),
        .inValid  (fInV),
        .inReady  (fInReady),
        .outData  (hhTx),
        .outValid (hhTxValid),
        .outReady (hhTxReady)
    );

    assign prnTxData      = prn_q;
    assign prnTxValid     = prnV_q;
    assign srcReq         = (st_q == ST_RPT) || (st_q == ST_PRINT);
    assign srcDocket      = (st_q == ST_PRINT);
    assign printDup       = dup_q;
    assign gateToPrinter  = (gate_q == GATE_PRN);
    assign devToPrinter   = (st_q == ST_PRINT);
    assign paperError     = (st_q == ST_PERR);
    assign deliveryPermit = txn_q;

    always_comb begin
        st_d   = st_q;
        ret_d  = ret_q;
        cmd_d  = cmd_q;
        gate_d = gate_q;
        code_d = code_q;
        idx_d  = idx_q;
        sum_d  = sum_q;
        orig_d = orig_q;
        txn_d  = txn_q;
        eod_d  = eod_q;
        dup_d  = dup_q;
        unpr_d = unpr_q;
        prn_d  = prn_q;
        prnV_d = prnV_q && !prnTxReady;
        frm_d  = frm_q;
        cnt_d  = cnt_q;
        c0_d   = c0_q;
        c1_d   = c1_q;
        esc_d  = esc_q;
        gap_d  = frm_q ? gap_q + 28'h1 : '0;
        fIn    = '0;
        fInV   = 1'b0;
        srcReady = 1'b0;
        // receive side: framing, timeout, gate escapes
        if (frm_q && gap_q == GAP_LAST) begin
            frm_d = 1'b0; // RULE17
        end
        if (hhRxValid) begin
            gap_d = '0;
            esc_d = (hhRxData != `SPS_ESC) ? 2'h0 : (esc_q == 2'h2) ? 2'h2 : esc_q + 2'h1;
            if (esc_q == 2'h2 && hhRxData == `SPS_GATE_DEV) begin
                gate_d = GATE_DEV; // RULE1
            end
            if (esc_q == 2'h2 && hhRxData == `SPS_GATE_PRN) begin
                gate_d = GATE_PRN; // RULE2
            end
            if (gate_q == GATE_PRN) begin
                if (st_q != ST_PRINT) begin
                    prn_d  = hhRxData; // RULE23
                    prnV_d = 1'b1;
                end
            end else if (hhRxData == `SPS_COLON) begin
                frm_d = 1'b1; // RULE16
                cnt_d = 2'h0;
            end else if (frm_q) begin
                if (hhRxData == `SPS_CR) begin
                    frm_d = 1'b0;
                    if (cnt_q == 2'h2 && cmd_q == CMD_NONE) begin
                        cmd_d = decode({c0_q, c1_q}); // RULE15
                    end
                end else begin
                    if (cnt_q == 2'h0) begin
                        c0_d = upcase(hhRxData);
                    end
                    if (cnt_q == 2'h1) begin
                        c1_d = upcase(hhRxData);
                    end
                    if (cnt_q != 2'h3) begin
                        cnt_d = cnt_q + 2'h1;
                    end
                end
            end
        end
        // sequencer; received bytes never reach the fifo
        case (st_q) // RULE19
            ST_IDLE: begin
                if (cmd_q != CMD_NONE) begin // RULE20
                    cmd_d = CMD_NONE;
                    idx_d = 3'h0;
                    st_d  = ST_MSG;
                    ret_d = ST_IDLE;
                    case (cmd_q)
                        CMD_TC: begin
                            txn_d  = 1'b1; // RULE6
                            code_d = `SPS_ST_S00;
                        end
                        CMD_PR: begin
                            dup_d  = orig_q; // RULE11
                            code_d = orig_q ? `SPS_ST_S09 : `SPS_ST_S08;
                            ret_d  = ST_PCHK; // RULE10
                        end
                        default: begin
                            st_d  = ST_RPT;
                            sum_d = 8'h0;
                        end
                    endcase
                end else if (eod_q && !frm_q) begin
                    eod_d  = 1'b0; // RULE3
                    orig_d = 1'b0;
                    txn_d  = 1'b0;
                    dup_d  = 1'b0;
                    unpr_d = 1'b0;
                    code_d = `SPS_ST_S08;
                    idx_d  = 3'h0;
                    st_d   = ST_MSG;
                    ret_d  = ST_PCHK;
                end else if (stopKey && unpr_q) begin
                    dup_d  = 1'b0; // RULE10
                    code_d = `SPS_ST_S08;
                    idx_d  = 3'h0;
                    st_d   = ST_MSG;
                    ret_d  = ST_PCHK;
                end
            end
            ST_MSG: begin
                fInV = 1'b1;
                fIn  = '{last: (idx_q == 3'h6), data: msgByte(idx_q, code_q, devId)}; // RULE18
                if (fInReady) begin
                    if (idx_q == 3'h6) begin
                        st_d = ret_q;
                    end else begin
                        idx_d = idx_q + 3'h1;
                    end
                end
            end
            ST_RPT: begin
                fInV     = srcValid;
                fIn      = '{last: 1'b0, data: srcData.data};
                srcReady = fInReady;
                if (srcValid && fInReady) begin
                    sum_d = sum_q + srcData.data;
                    if (srcData.last) begin
                        st_d = ST_CHK;
                    end
                end
            end
            ST_CHK: begin
                fInV = 1'b1;
                fIn  = '{last: 1'b0, data: 8'h0 - sum_q}; // RULE21
                if (fInReady) begin
                    idx_d = 3'h5;
                    ret_d = ST_IDLE;
                    st_d  = ST_MSG;
                end
            end
            ST_PCHK: begin
                // paper is sampled here and in ST_PERR, never on a test key
                st_d = (!slip42 || paperPresent) ? ST_PRINT : ST_PERR; // RULE8 RULE13
            end
            ST_PERR: begin
                if (paperPresent) begin
                    st_d = ST_PRINT; // RULE9
                end else if (stopKey) begin
                    gate_d = GATE_DEV; // RULE9
                    unpr_d = 1'b1;
                    code_d = `SPS_ST_S10;
                    idx_d  = 3'h0;
                    st_d   = ST_MSG;
                    ret_d  = ST_IDLE;
                end
            end
            ST_PRINT: begin
                // text arrives already placed for the printer width
                srcReady = !prnV_q || prnTxReady; // RULE4 RULE14
                if (srcValid && srcReady) begin
                    prn_d  = srcData.data;
                    prnV_d = 1'b1;
                    if (srcData.last) begin
                        gate_d = GATE_DEV; // RULE5
                        orig_d = 1'b1;
                        unpr_d = 1'b0;
                        code_d = `SPS_ST_S01;
                        idx_d  = 3'h0;
                        st_d   = ST_MSG;
                        ret_d  = ST_IDLE;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // end of delivery wins over any other gate change
        if (endOfDelivery) begin
            eod_d  = 1'b1; // RULE3
            gate_d = GATE_DEV;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q   <= ST_IDLE;
            ret_q  <= ST_IDLE;
            cmd_q  <= CMD_NONE;
            gate_q <= GATE_DEV;
            code_q <= `SPS_ST_S00;
            idx_q  <= 3'h0;
            sum_q  <= 8'h0;
            orig_q <= 1'b0;
            txn_q  <= 1'b1;
            eod_q  <= 1'b0;
            dup_q  <= 1'b0;
            unpr_q <= 1'b0;
            prn_q  <= 8'h0;
            prnV_q <= 1'b0;
            frm_q  <= 1'b0;
            cnt_q  <= 2'h0;
            c0_q   <= 8'h0;
            c1_q   <= 8'h0;
            esc_q  <= 2'h0;
            gap_q  <= '0;
        end else begin
            st_q   <= st_d;
            ret_q  <= ret_d;
            cmd_q  <= cmd_d;
            gate_q <= gate_d;
            code_q <= code_d;
            idx_q  <= idx_d;
            sum_q  <= sum_d;
            orig_q <= orig_d;
            txn_q  <= txn_d;
            eod_q  <= eod_d;
            dup_q  <= dup_d;
            unpr_q <= unpr_d;
            prn_q  <= prn_d;
            prnV_q <= prnV_d;
            frm_q  <= frm_d;
            cnt_q  <= cnt_d;
            c0_q   <= c0_d;
            c1_q   <= c1_d;
            esc_q  <= esc_d;
            gap_q  <= gap_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_gate_dev_esc: assert property (hhRxValid && esc_q == 2'h2 // RULE1
        && hhRxData == `SPS_GATE_DEV |=> gate_q == GATE_DEV) else $error("esc Y missed");
    chk_gate_prn_esc: assert property (hhRxValid && esc_q == 2'h2 && !endOfDelivery // RULE2
        && hhRxData == `SPS_GATE_PRN |=> gate_q == GATE_PRN) else $error("esc Z missed");
    chk_eod_s08: assert property (endOfDelivery && st_q == ST_IDLE && !frm_q // RULE3
        && cmd_q == CMD_NONE |=> gate_q == GATE_DEV ##1 st_q == ST_MSG
        && code_q == `SPS_ST_S08) else $error("eod not announced");
    chk_tc_s00: assert property (st_q == ST_IDLE && cmd_q == CMD_TC // RULE6
        |=> st_q == ST_MSG && code_q == `SPS_ST_S00 && txn_q) else $error("tc not answered");
    chk_paper_hold: assert property (st_q == ST_PCHK && slip42 && !paperPresent // RULE8
        |=> st_q == ST_PERR && paperError) else $error("no paper error");
    chk_stop_s10: assert property (st_q == ST_PERR && !paperPresent && stopKey // RULE9
        |=> st_q == ST_MSG && code_q == `SPS_ST_S10 && !gateToPrinter) else $error("no S10");
    chk_msg_tail: assert property (st_q == ST_MSG && idx_q == 3'h5 && fInReady // RULE18
        |-> fIn.data == `SPS_CR ##1 fIn.data == `SPS_LF && fIn.last) else $error("bad tail");
    chk_frame_colon: assert property (hhRxValid && hhRxData == `SPS_COLON // RULE16
        && gate_q == GATE_DEV |=> frm_q && cnt_q == 2'h0) else $error("colon ignored");
    chk_gap_clear: assert property (frm_q && gap_q == GAP_LAST && !hhRxValid // RULE17
        |=> !frm_q) else $error("gap kept frame");
    chk_answer_soon: assert property (st_q == ST_IDLE && cmd_q != CMD_NONE // RULE20
        && cmd_q != CMD_RPT |-> ##[1:2] fInV) else $error("slow answer");
    chk_no_echo: assert property (gate_q == GATE_DEV && st_q != ST_PRINT && !prnV_q // RULE19
        |=> !prnV_q) else $error("received byte echoed");
endmodule // sps_gate

//--- sps_far_end.sv
// hand-held and printer model: takes the bytes the gate sends on both sides
// assumes valid held until ready, all on the rising edge of sys_clk
`timescale 1ns/100ps
module sps_far_end import sps_pkg::*; (
    input  wire logic       sys_clk,    // system clock
    input  wire logic       arst_n,     // async reset
    input  wire logic       slow,       // stall every other cycle
    input  sps_byte_s       hhTx,       // byte from device
    input  wire logic       hhTxValid,  // byte waiting
    output logic            hhTxReady,  // hand-held takes byte
    input  wire logic [7:0] prnTxData,  // byte to printer
    input  wire logic       prnTxValid, // byte waiting
    output logic            prnTxReady  // printer takes byte
);
    logic [7:0] hhQ[$];
    logic [7:0] prnQ[$];
    int         nLast = 0;

    // ----------------------------------------------------------------
    // receive sides
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hhTxReady  <= 1'b0;
            prnTxReady <= 1'b0;
        end else begin
            hhTxReady  <= slow ? ~hhTxReady : 1'b1;
            prnTxReady <= slow ? ~prnTxReady : 1'b1;
            if (hhTxValid && hhTxReady) hhQ.push_back(hhTx.data);
            if (hhTxValid && hhTxReady && hhTx.last) nLast++;
            if (prnTxValid && prnTxReady) prnQ.push_back(prnTxData);
        end
    end
endmodule // sps_far_end

//--- testbench.sv
// self-checking bench of the serial print gate
// assumes sps_gate with a short gap count and the far-end model beside it
`timescale 1ns/100ps
module testbench import sps_pkg::*;;
    logic       sys_clk, arst_n, hhRxValid, hhTxValid, hhTxReady, prnTxValid, prnTxReady;
    logic       endOfDelivery, stopKey, paperPresent, slip42, srcValid, srcReady;
    logic       srcReq, srcDocket, printDup, gateToPrinter, devToPrinter;
    logic       paperError, deliveryPermit, slow;
    logic [7:0] hhRxData, prnTxData, devId, b;
    sps_byte_s  hhTx, srcData;
    logic [7:0] txt[3] = '{8'h31, 8'h32, 8'h33};
    int         n_errors = 0, checks = 0, srcIdx = 0;

    sps_gate #(.GAP_CYC(20)) u_dut (
        .sys_clk        (sys_clk),
        .arst_n         (arst_n),
        .hhRxData       (hhRxData),
        .hhRxValid      (hhRxValid),
        .hhTx           (hhTx),
        .hhTxValid      (hhTxValid),
        .hhTxReady      (hhTxReady),
        .prnTxData      (prnTxData),
        .prnTxValid     (prnTxValid),
        .prnTxReady     (prnTxReady),
        .endOfDelivery  (endOfDelivery),
        .stopKey        (stopKey),
        .paperPresent   (paperPresent),
        .slip42         (slip42),
        .devId          (devId),
        .srcData        (srcData),
        .srcValid       (srcValid),
        .srcReady       (srcReady),
        .srcReq         (srcReq),
        .srcDocket      (srcDocket),
        .printDup       (printDup),
        .gateToPrinter  (gateToPrinter),
        .devToPrinter   (devToPrinter),
        .paperError     (paperError),
        .deliveryPermit (deliveryPermit)
    );
    sps_far_end u_far (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .hhTx(hhTx),
        .hhTxValid(hhTxValid), .hhTxReady(hhTxReady), .prnTxData(prnTxData),
        .prnTxValid(prnTxValid), .prnTxReady(prnTxReady));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // text source: three bytes, last on the third
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        automatic int n = srcIdx;
        if (!srcReq) n = 0;
        else if (srcValid && srcReady) n = n + 1;
        srcIdx   <= n;
        srcValid <= srcReq && n < 3;
        srcData  <= '{last: (n == 2), data: txt[n % 3]};
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sendStr(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge sys_clk);
            hhRxData  <= s[i];
            hhRxValid <= 1'b1;
        end
        @(posedge sys_clk);
        hhRxValid <= 1'b0;
    endtask

    task automatic getHh(input int bound);
        int k;
        k = 0;
        while (u_far.hhQ.size() == 0 && k < bound) begin
            @(negedge sys_clk);
            k++;
        end
        if (u_far.hhQ.size() == 0) begin
            b = 8'hxx;
            check(16'h0000, 16'h0001);
        end else b = u_far.hhQ.pop_front();
    endtask

    task automatic expectStatus(input logic [15:0] code, input int bound);
        logic [55:0] exp;
        exp = {devId, 8'h20, 8'h53, code, 8'h0d, 8'h0a};
        for (int i = 6; i >= 0; i--) begin
            getHh(bound);
            check({8'h00, b}, {8'h00, exp[i*8 +: 8]});
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic pulseEod();
        @(posedge sys_clk);
        endOfDelivery <= 1'b1;
        @(posedge sys_clk);
        endOfDelivery <= 1'b0;
    endtask

    task automatic pulseStop();
        @(posedge sys_clk);
        stopKey <= 1'b1;
        @(posedge sys_clk);
        stopKey <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_framing();
        sendStr("TC\r");
        sendStr(":T");
        idle(30);
        sendStr("C\r");
        idle(20);
        check(16'(u_far.hhQ.size()), 16'h0000);
        sendStr(":X:TC\r");
        expectStatus(16'h3030, 4);
        check({15'h0, deliveryPermit}, 16'h0001);
    endtask

    task automatic t_gates();
        sendStr("\033\033Z");
        idle(2);
        check({15'h0, gateToPrinter}, 16'h0001);
        u_far.prnQ.delete();
        sendStr(":TC\r");
        sendStr("\033\033Y");
        idle(5);
        check({15'h0, gateToPrinter}, 16'h0000);
        check(16'(u_far.hhQ.size()), 16'h0000);
        check({u_far.prnQ[0], u_far.prnQ[3]}, 16'h3a0d);
    endtask

    task automatic t_delivery();
        u_far.prnQ.delete();
        sendStr("\033\033Z");
        pulseEod();
        expectStatus(16'h3038, 40);
        check({15'h0, gateToPrinter}, 16'h0000);
        check({15'h0, deliveryPermit}, 16'h0000);
        expectStatus(16'h3031, 200);
        check(16'(u_far.prnQ.size()), 16'h0003);
        for (int i = 0; i < 3; i++) check({8'h00, u_far.prnQ[i]}, {8'h00, txt[i]});
        check({15'h0, gateToPrinter}, 16'h0000);
        check({15'h0, printDup}, 16'h0000);
    endtask

    task automatic t_paper();
        u_far.prnQ.delete();
        @(posedge sys_clk);
        paperPresent <= 1'b0;
        pulseEod();
        expectStatus(16'h3038, 40);
        idle(10);
        check({15'h0, paperError}, 16'h0001);
        check(16'(u_far.prnQ.size()), 16'h0000);
        pulseStop();
        expectStatus(16'h3130, 40);
        check({15'h0, paperError}, 16'h0000);
        pulseStop();
        expectStatus(16'h3038, 40);
        idle(10);
        check({15'h0, paperError}, 16'h0001);
        @(posedge sys_clk);
        paperPresent <= 1'b1;
        idle(2);
        check({14'h0, devToPrinter, srcDocket}, 16'h0003);
        expectStatus(16'h3031, 200);
        check(16'(u_far.prnQ.size()), 16'h0003);
        sendStr(":pr\r");
        expectStatus(16'h3039, 40);
        expectStatus(16'h3031, 200);
        check(16'(u_far.prnQ.size()), 16'h0006);
        check({15'h0, printDup}, 16'h0001);
    endtask

    task automatic t_report();
        logic [7:0] sum, exp[6];
        sum = 8'h00;
        exp = '{txt[0], txt[1], txt[2], 8'h00 - (txt[0] + txt[1] + txt[2]), 8'h0d, 8'h0a};
        slow <= 1'b1;
        sendStr(":T?\r");
        for (int i = 0; i < 6; i++) begin
            getHh(200);
            if (i < 4) sum = sum + b;
            check({8'h00, b}, {8'h00, exp[i]});
        end
        check({8'h00, sum}, 16'h0000);
        slow <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        {hhRxValid, endOfDelivery, stopKey, slow} = '0;
        {paperPresent, slip42} = 2'b11;
        hhRxData = 8'h00;
        devId = 8'h37;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_framing();
        t_gates();
        t_delivery();
        t_paper();
        t_report();
        sendStr(":TC\r");
        expectStatus(16'h3030, 4);
        check({15'h0, deliveryPermit}, 16'h0001);
        check(16'(u_far.nLast), 16'h000b);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
endmodule // testbench
